// ==== pbcr_pkg.sv ====
package pbcr_pkg;

  // ===========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_ID     = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;

  // ===========================================================
  // Field positions in the identification dword
  localparam int VEN_LSB = 0;
  localparam int DEV_LSB = 16;

  // ===========================================================
  // Command bit positions
  localparam int CMD_IO    = 0;
  localparam int CMD_MEM   = 1;
  localparam int CMD_BME   = 2;
  localparam int CMD_PERR  = 6;
  localparam int CMD_SERR  = 8;
  localparam int CMD_INTD  = 10;

  // Writable command bits; all others read zero
  localparam logic [15:0] CMD_WMASK = 16'h0547;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // ===========================================================
  // Status half of the command dword
  localparam int STS_MDPE = 24;
  localparam logic STS_RESET = 1'b0;

  // ===========================================================
  // Configuration access timing
  localparam int CFG_LATENCY = 1;

  // ===========================================================
  // Configuration request carrier
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pbcr_cfg_req_s;

  // Transaction kind seen on either side of the port
  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_mem;
    logic non_posted;
  } pbcr_txn_s;

endpackage

// ==== pbcr_gate.sv ====
`timescale 1ns/1ps
module pbcr_gate #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] in_i,
  output logic      [W-1:0] q_o
);

  // ===========================================================
  // Registered gating of event pulses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else begin
      q_o <= en_i ? in_i : '0;
    end
  end

endmodule

// ==== pbcr_regs.sv ====
`timescale 1ns/1ps
module pbcr_regs #(
  parameter logic [15:0] VENDOR_DEFAULT = 16'h1A5C, // Arbitrary value
  parameter logic [15:0] DEVICE_DEFAULT = 16'h0E71  // Arbitrary value
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Configuration access
  input  wire pbcr_pkg::pbcr_cfg_req_s cfg_req_i,
  output logic                        cfg_ack_o,
  output logic [31:0]                 cfg_rdata_o,
  // Identity override from SMBus or EEPROM autoload
  input  wire logic                   id_load_vendor_i,
  input  wire logic                   id_load_device_i,
  input  wire logic [15:0]            id_value_i,
  // Primary-side transactions
  input  wire pbcr_pkg::pbcr_txn_s     pri_txn_i,
  output logic                        pri_io_claim_o,
  output logic                        pri_mem_claim_o,
  // Downstream-side requests heading upstream
  input  wire pbcr_pkg::pbcr_txn_s     ds_txn_i,
  output logic                        up_forward_o,
  output logic                        ds_ur_o,
  output logic                        ds_ur_cpl_o,
  // Parity and error events
  input  wire logic                   parity_err_i,
  output logic                        parity_action_o,
  input  wire logic                   err_event_i,
  output logic                        err_report_o,
  // INTx
  input  wire logic                   own_intx_i,
  output logic                        own_intx_o,
  input  wire logic                   fwd_intx_i,
  output logic                        fwd_intx_o,
  // Current state
  output logic [15:0]                 cmd_o,
  output logic                        mdpe_o
);

  // ===========================================================
  // State
  logic [15:0] vendor_q;
  logic [15:0] vendor_d;
  logic [15:0] device_q;
  logic [15:0] device_d;
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic        mdpe_q;
  logic        mdpe_d;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // ===========================================================
  // Decode
  wire         hit_id;
  wire         hit_cmd;
  wire         wr_cmd;
  wire  [15:0] wr_lanes;
  wire  [15:0] cmd_wr_val;
  wire         mdpe_set;
  wire         mdpe_clr;
  wire         io_en;
  wire         mem_en;
  wire         bme;
  wire         perr_en;
  wire         serr_en;
  wire         intx_dis;
  wire         ds_memio;

  assign hit_id   = cfg_req_i.valid && (cfg_req_i.addr == pbcr_pkg::OFS_ID);
  assign hit_cmd  = cfg_req_i.valid && (cfg_req_i.addr == pbcr_pkg::OFS_CMD);
  assign wr_cmd   = hit_cmd && cfg_req_i.write;
  assign wr_lanes = {{8{cfg_req_i.be[1]}}, {8{cfg_req_i.be[0]}}};

  // Only writable bits take the new value
  assign cmd_wr_val = (cmd_q & ~(wr_lanes & pbcr_pkg::CMD_WMASK)) |
                      (cfg_req_i.wdata[15:0] & wr_lanes &
                       pbcr_pkg::CMD_WMASK);

  assign io_en    = cmd_q[pbcr_pkg::CMD_IO];
  assign mem_en   = cmd_q[pbcr_pkg::CMD_MEM];
  assign bme      = cmd_q[pbcr_pkg::CMD_BME];
  assign perr_en  = cmd_q[pbcr_pkg::CMD_PERR];
  assign serr_en  = cmd_q[pbcr_pkg::CMD_SERR];
  assign intx_dis = cmd_q[pbcr_pkg::CMD_INTD];

  // Flag set only with parity response enabled
  assign mdpe_set = parity_err_i && perr_en;
  assign mdpe_clr = wr_cmd && cfg_req_i.be[3] &&
                    cfg_req_i.wdata[pbcr_pkg::STS_MDPE];

  assign ds_memio = ds_txn_i.valid && (ds_txn_i.is_io || ds_txn_i.is_mem);

  // ===========================================================
  // Next-state logic
  always_comb begin
    vendor_d = vendor_q;
    device_d = device_q;
    if (id_load_vendor_i) begin
      vendor_d = id_value_i;
    end
    if (id_load_device_i) begin
      device_d = id_value_i;
    end
  end

  always_comb begin
    cmd_d = cmd_q;
    if (wr_cmd) begin
      cmd_d = cmd_wr_val;
    end
  end

  // Set wins over a simultaneous clear
  always_comb begin
    mdpe_d = mdpe_q;
    if (mdpe_clr) begin
      mdpe_d = 1'b0;
    end
    if (mdpe_set) begin
      mdpe_d = 1'b1;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_id && !cfg_req_i.write) begin
      rdata_d[pbcr_pkg::VEN_LSB +: 16] = vendor_q;
      rdata_d[pbcr_pkg::DEV_LSB +: 16] = device_q;
    end else if (hit_cmd && !cfg_req_i.write) begin
      rdata_d[15:0] = cmd_q & pbcr_pkg::CMD_WMASK;
      rdata_d[pbcr_pkg::STS_MDPE] = mdpe_q;
    end
  end

  // ===========================================================
  // Registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vendor_q <= VENDOR_DEFAULT;
      device_q <= DEVICE_DEFAULT;
    end else begin
      vendor_q <= vendor_d;
      device_q <= device_d;
    end
  end

  // Command bits all reset to zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_q  <= pbcr_pkg::CMD_RESET;
      mdpe_q <= pbcr_pkg::STS_RESET;
    end else begin
      cmd_q  <= cmd_d;
      mdpe_q <= mdpe_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= cfg_req_i.valid;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_ack_o   = ack_q;
  assign cfg_rdata_o = rdata_q;
  assign cmd_o       = cmd_q;
  assign mdpe_o      = mdpe_q;

  // ===========================================================
  // Primary-side decode enables
  pbcr_gate #(.W(1)) u_io_claim (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (io_en),
    .in_i  (pri_txn_i.valid && pri_txn_i.is_io),
    .q_o   (pri_io_claim_o)
  );

  pbcr_gate #(.W(1)) u_mem_claim (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (mem_en),
    .in_i  (pri_txn_i.valid && pri_txn_i.is_mem),
    .q_o   (pri_mem_claim_o)
  );

  // ===========================================================
  // Upstream mastering
  pbcr_gate #(.W(1)) u_forward (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (bme),
    .in_i  (ds_memio),
    .q_o   (up_forward_o)
  );

  // Unsupported Request path while mastering is off
  pbcr_gate #(.W(2)) u_ur (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (!bme),
    .in_i  ({ds_memio, ds_memio && ds_txn_i.non_posted}),
    .q_o   ({ds_ur_o, ds_ur_cpl_o})
  );

  // ===========================================================
  // Parity and error reporting
  pbcr_gate #(.W(1)) u_parity (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (perr_en),
    .in_i  (parity_err_i),
    .q_o   (parity_action_o)
  );

  pbcr_gate #(.W(1)) u_err (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (serr_en),
    .in_i  (err_event_i),
    .q_o   (err_report_o)
  );

  // ===========================================================
  // INTx: own messages gated, forwarded ones untouched
  pbcr_gate #(.W(1)) u_own_intx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (!intx_dis),
    .in_i  (own_intx_i),
    .q_o   (own_intx_o)
  );

  pbcr_gate #(.W(1)) u_fwd_intx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (1'b1),
    .in_i  (fwd_intx_i),
    .q_o   (fwd_intx_o)
  );

endmodule

// ==== pbcr_regs_monitor.sv ====
`timescale 1ns/1ps
module pbcr_regs_monitor (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire pbcr_pkg::pbcr_txn_s pri_txn_i,
  input wire pbcr_pkg::pbcr_txn_s ds_txn_i,
  input wire logic                pri_io_claim_o,
  input wire logic                pri_mem_claim_o,
  input wire logic                up_forward_o,
  input wire logic                ds_ur_o,
  input wire logic                ds_ur_cpl_o,
  input wire logic                parity_err_i,
  input wire logic                parity_action_o,
  input wire logic                err_event_i,
  input wire logic                err_report_o,
  input wire logic                own_intx_i,
  input wire logic                own_intx_o,
  input wire logic                fwd_intx_i,
  input wire logic                fwd_intx_o,
  input wire logic [15:0]         cmd_o,
  input wire logic                mdpe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ===========================================================
  // Gating of events by command bits; fixed command bits stay zero
  sequence s_ds;
    ds_txn_i.valid && (ds_txn_i.is_mem || ds_txn_i.is_io);
  endsequence
  property p_io;
    pri_io_claim_o == $past(pri_txn_i.valid && pri_txn_i.is_io && cmd_o[0]);
  endproperty
  property p_mem;
    pri_mem_claim_o == $past(pri_txn_i.valid && pri_txn_i.is_mem && cmd_o[1]);
  endproperty
  property p_ur;
    s_ds ##0 !cmd_o[2] |=> ds_ur_o && !up_forward_o
      && (ds_ur_cpl_o == $past(ds_txn_i.non_posted));
  endproperty
  property p_fwd;
    s_ds ##0 cmd_o[2] |=> up_forward_o && !ds_ur_o && !ds_ur_cpl_o;
  endproperty
  property p_par;
    parity_err_i |=> parity_action_o == $past(cmd_o[6]);
  endproperty
  property p_err;
    $past(err_event_i) |-> err_report_o == $past(cmd_o[8]);
  endproperty
  property p_intx;
    (own_intx_o == $past(own_intx_i && !cmd_o[10]))
      && (fwd_intx_o == $past(fwd_intx_i));
  endproperty
  property p_rsv;
    (cmd_o & 16'hFAB8) == 16'h0000;
  endproperty
  property p_mdpe;
    $rose(mdpe_o) |-> $past(parity_err_i && cmd_o[6]);
  endproperty
  a_io: assert property (p_io) else $error("io claim wrong");
  a_mem: assert property (p_mem) else $error("mem claim wrong");
  a_ur: assert property (p_ur) else $error("ur wrong");
  a_fwd: assert property (p_fwd) else $error("forward wrong");
  a_par: assert property (p_par) else $error("parity wrong");
  a_err: assert property (p_err) else $error("report wrong");
  a_intx: assert property (p_intx) else $error("intx wrong");
  a_rsv: assert property (p_rsv) else $error("fixed bit set");
  a_mdpe: assert property (p_mdpe) else $error("mdpe set");
endmodule

bind pbcr_regs pbcr_regs_monitor u_mon (.*);

// ==== pbcr_rc_model.sv ====
`timescale 1ns/1ps
module pbcr_rc_model (
  input  wire logic              clk_i,
  input  wire logic              ack_i,
  input  wire logic [31:0]       rdata_i,
  output pbcr_pkg::pbcr_cfg_req_s req_o
);
  initial req_o = '0;
  // One config access: pulse, then take the answer
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    #1;
    req_o = '{1'b1, w, a, be, d};
    @(posedge clk_i);
    #1;
    // Released lines show inverse of last value
    req_o = '{1'b0, ~w, ~a, ~be, ~d};
    q = ack_i ? rdata_i : 32'hXXXXXXXX;
  endtask
endmodule

// ==== test_pbcr_regs.sv ====
`timescale 1ns/1ps
module test_pbcr_regs;
  localparam logic [15:0] VEN = 16'h2B3D; // Arbitrary value
  localparam logic [15:0] DEV = 16'h4C6E; // Arbitrary value
  logic                    clk_i = 0;
  logic                    rst_i = 1;
  pbcr_pkg::pbcr_cfg_req_s req;
  pbcr_pkg::pbcr_txn_s     pri = '0;
  pbcr_pkg::pbcr_txn_s     ds = '0;
  logic                    ack, ldv = 0, ldd = 0, par = 0, err = 0;
  logic                    oi = 0, fi = 0, io_c, mem_c, fwd, ur, urc;
  logic                    pa, er, oo, fo, mdpe;
  logic [15:0]             idv = 16'h0000, cmd;
  logic [31:0]             rd;
  logic [15:0]             pats [4] = '{16'hFFFF, 16'h0000, 16'h0142,
                                        16'h0405};
  int                      mismatches = 0, checked = 0;
  always #25 clk_i = ~clk_i;
  pbcr_rc_model rc (.clk_i(clk_i), .ack_i(ack), .rdata_i(rd), .req_o(req));
  pbcr_regs #(.VENDOR_DEFAULT(VEN), .DEVICE_DEFAULT(DEV)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_req_i(req), .cfg_ack_o(ack),
    .cfg_rdata_o(rd), .id_load_vendor_i(ldv), .id_load_device_i(ldd),
    .id_value_i(idv), .pri_txn_i(pri), .pri_io_claim_o(io_c),
    .pri_mem_claim_o(mem_c), .ds_txn_i(ds), .up_forward_o(fwd),
    .ds_ur_o(ur), .ds_ur_cpl_o(urc), .parity_err_i(par),
    .parity_action_o(pa), .err_event_i(err), .err_report_o(er),
    .own_intx_i(oi), .own_intx_o(oo), .fwd_intx_i(fi), .fwd_intx_o(fo),
    .cmd_o(cmd), .mdpe_o(mdpe));
  // ===========================================================
  // Check and access helpers
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [3:0] be, logic [31:0] d);
    logic [31:0] x;
    rc.xfer(1'b1, a, be, d, x);
  endtask
  task automatic rdc(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] x;
    rc.xfer(1'b0, a, 4'hF, 32'h0, x);
    chk(n, e, x);
  endtask
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  // Fire all events with command c in force
  task automatic events(logic [15:0] c);
    tick();
    pri = '{1'b1, 1'b1, 1'b0, 1'b1};
    ds = '{1'b1, 1'b0, 1'b1, 1'b1};
    {par, err, oi, fi} = 4'hF;
    tick();
    pri = '{1'b1, 1'b0, 1'b1, 1'b0};
    ds = '{1'b1, 1'b1, 1'b0, 1'b0};
    {par, err, oi, fi} = 4'h0;
    chk("io", {31'h0, c[0]}, {31'h0, io_c});
    chk("fwd", {31'h0, c[2]}, {31'h0, fwd});
    chk("ur", {30'h0, ~c[2], ~c[2]}, {30'h0, ur, urc});
    chk("par", {31'h0, c[6]}, {31'h0, pa});
    chk("err", {31'h0, c[8]}, {31'h0, er});
    chk("intx", {30'h0, ~c[10], 1'b1}, {30'h0, oo, fo});
    tick();
    pri = '0;
    ds = '0;
    chk("mem", {31'h0, c[1]}, {31'h0, mem_c});
    chk("mdpe", {31'h0, c[6]}, {31'h0, mdpe});
    chk("ur posted", {30'h0, ~c[2], 1'b0}, {30'h0, ur, urc});
    chk("fwd io", {31'h0, c[2]}, {31'h0, fwd});
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  // ===========================================================
  // Tests
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 0;
    rdc("id", 8'h00, {DEV, VEN});
    rdc("cmd", 8'h04, 32'h0);
    wr(8'h00, 4'hF, 32'h12345678);
    rdc("id ro", 8'h00, {DEV, VEN});
    rdc("unmapped", 8'h08, 32'h0);
    $display("reset and id test done");
    foreach (pats[i]) begin
      wr(8'h04, 4'hF, {16'h0100, pats[i]});
      rdc("cmd", 8'h04, {16'h0, pats[i] & 16'h0547});
      events(pats[i]);
    end
    $display("command gating test done");
    wr(8'h04, 4'h1, 32'h0);
    wr(8'h04, 4'h2, 32'hFFFFFFFF);
    rdc("be", 8'h04, 32'h00000500);
    $display("byte enable test done");
    wr(8'h04, 4'h3, 32'h00000040);
    par = 1;
    wr(8'h04, 4'hF, 32'h01000040);
    par = 0;
    rdc("mdpe set wins", 8'h04, 32'h01000040);
    wr(8'h04, 4'h7, 32'h01000040);
    chk("mdpe kept", 32'h1, {31'h0, mdpe});
    wr(8'h04, 4'hF, 32'h01000040);
    rdc("mdpe clear", 8'h04, 32'h00000040);
    chk("cmd_o", 32'h00000040, {16'h0, cmd});
    $display("status flag test done");
    tick();
    idv = 16'h9E21;
    ldv = 1;
    tick();
    ldv = 0;
    idv = 16'h61DE;
    ldd = 1;
    tick();
    ldd = 0;
    idv = 16'h0000;
    rdc("id load", 8'h00, {16'h61DE, 16'h9E21});
    tick();
    rst_i = 1;
    tick();
    rst_i = 0;
    rdc("id reset", 8'h00, {DEV, VEN});
    rdc("cmd reset", 8'h04, 32'h0);
    chk("cmd_o reset", 32'h0, {16'h0, cmd});
    $display("id load and reset test done");
    print_verdict();
  end
endmodule
